// file: amot_regs.sv
`timescale 1ns/1ps
// Function
// - Mask bit 5 gates lane-buffer fault
// - Mask bit 4 gates serdes lock loss
// - Mask bit 3 gates link-state fault
// - Mask bit 2 gates clock realign
// - Mask bit 0 gates divider mismatch
// - Mask register resets to 0x3f
// - Lane fifo fault on an active lane sets its lane bit
// - Writing one clears a lane bit
// - Clearing summary lane fault clears all lanes
// - Lane register resets to all ones
// - Trim is unsigned 12-bit, drives core0
// - Second trim drives core one
// - Third trim drives core two input A
// - Trim defaults come from fuse memory
// - Summary alarm on any unmasked source flag
// - Any active lane fault sets summary flag
`include "amot_cfg.svh"
module amot_regs
  import amot_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire amot_addr_t       reg_addr,
  input  wire amot_word_t       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output amot_word_t            reg_rdata,
  input  wire logic [LANES-1:0] lane_active,
  input  wire logic [LANES-1:0] lane_fifo_err,
  input  wire logic             serdes_lock_lost,
  input  wire logic             link_state_fault,
  input  wire logic             clock_realigned,
  input  wire logic             divider_mismatch,
  input  wire logic             fuse_load,
  input  wire amot_trim_t       fuse_core0_trim,
  input  wire amot_trim_t       fuse_core1_trim,
  input  wire amot_trim_t       fuse_core2_input_a_trim,
  output logic                  alarm_out,
  output amot_trim_t            core0_offset,
  output amot_trim_t            core1_offset,
  output amot_trim_t            core2_input_a_offset
);

  amot_byte_t alarm_source_mask;
  amot_byte_t alarm_status_flags;
  logic [LANES-1:0] lane_buffer_fault_flags;
  amot_word_t core0_offset_trim;
  amot_word_t core1_offset_trim;
  amot_word_t core2_input_a_offset_trim;

  // Write decode per register
  wire wr_mask   = reg_wr && (reg_addr == `AMOT_ADDR_MASK);
  wire wr_status = reg_wr && (reg_addr == `AMOT_ADDR_STATUS);
  wire wr_lane   = reg_wr && (reg_addr == `AMOT_ADDR_LANE);
  wire wr_trim0  = reg_wr && (reg_addr == `AMOT_ADDR_TRIM0);
  wire wr_trim1  = reg_wr && (reg_addr == `AMOT_ADDR_TRIM1);
  wire wr_trim2a = reg_wr && (reg_addr == `AMOT_ADDR_TRIM2A);

  // Hardware events, lane faults only count on active lanes
  wire [LANES-1:0] lane_event = lane_fifo_err & lane_active;
  wire             lane_any   = |lane_event;
  amot_byte_t status_event;
  assign status_event = {2'b00, lane_any, serdes_lock_lost, link_state_fault,
                         clock_realigned, 1'b0, divider_mismatch};

  // Write-one-to-clear; a new event in the same cycle wins
  wire        clr_lane_all = wr_status && reg_wdata[`AMOT_BIT_LANE_BUF];
  wire [LANES-1:0] lane_clr = clr_lane_all ? '1 : (wr_lane ? reg_wdata[LANES-1:0] : '0);
  wire [LANES-1:0] next_lane = (lane_buffer_fault_flags & ~lane_clr) | lane_event;
  amot_byte_t status_clr;
  assign status_clr = wr_status ? reg_wdata[7:0] : 8'h00;
  amot_byte_t next_status;
  assign next_status = (alarm_status_flags & ~status_clr) | status_event;
  amot_byte_t next_mask;
  assign next_mask = wr_mask ? reg_wdata[7:0] : alarm_source_mask;

  // Summary: any unmasked source flag
  function automatic logic summary(input amot_byte_t st, input amot_byte_t mk);
    summary = |(st & ~mk & `AMOT_ALARM_SRC);
  endfunction

  // Trim update: software write, else fuse default load
  function automatic amot_word_t trim_next(input logic wr, input amot_word_t wd,
                                           input logic ld, input amot_trim_t fuse,
                                           input amot_word_t cur);
    if (wr) begin
      trim_next = wd;
    end else if (ld) begin
      trim_next = {4'h0, fuse};
    end else begin
      trim_next = cur;
    end
  endfunction

  // Alarm and lane registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_source_mask       <= `AMOT_RST_MASK;
      alarm_status_flags      <= `AMOT_RST_STATUS;
      lane_buffer_fault_flags <= '1;
      alarm_out               <= 1'b0;
    end else if (ce) begin
      alarm_source_mask       <= next_mask;
      alarm_status_flags      <= next_status;
      lane_buffer_fault_flags <= next_lane;
      alarm_out               <= summary(next_status, next_mask);
    end
  end

  // Offset trim registers
  // Calibration access limits rest with software; nothing here blocks a trim write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core0_offset_trim         <= `AMOT_RST_TRIM;
      core1_offset_trim         <= `AMOT_RST_TRIM;
      core2_input_a_offset_trim <= `AMOT_RST_TRIM;
    end else if (ce) begin
      core0_offset_trim <= trim_next(wr_trim0, reg_wdata, fuse_load, fuse_core0_trim,
                                     core0_offset_trim);
      core1_offset_trim <= trim_next(wr_trim1, reg_wdata, fuse_load, fuse_core1_trim,
                                     core1_offset_trim);
      core2_input_a_offset_trim <= trim_next(wr_trim2a, reg_wdata, fuse_load,
                                             fuse_core2_input_a_trim,
                                             core2_input_a_offset_trim);
    end
  end

  // Low 12 bits feed the converter cores
  assign core0_offset         = core0_offset_trim[11:0];
  assign core1_offset         = core1_offset_trim[11:0];
  assign core2_input_a_offset = core2_input_a_offset_trim[11:0];

  // Read mux, unmapped reads return zero
  amot_word_t rd_mux;
  always_comb begin
    unique case (reg_addr)
      `AMOT_ADDR_SUMMARY: rd_mux = {15'h0000, alarm_out};
      `AMOT_ADDR_STATUS:  rd_mux = {8'h00, alarm_status_flags};
      `AMOT_ADDR_MASK:    rd_mux = {8'h00, alarm_source_mask};
      `AMOT_ADDR_LANE:    rd_mux = 16'(lane_buffer_fault_flags);
      `AMOT_ADDR_TRIM0:   rd_mux = core0_offset_trim;
      `AMOT_ADDR_TRIM1:   rd_mux = core1_offset_trim;
      `AMOT_ADDR_TRIM2A:  rd_mux = core2_input_a_offset_trim;
      default:            rd_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Helper: mask not yet written since reset
  logic mask_untouched;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_untouched <= 1'b1;
    end else if (ce && wr_mask) begin
      mask_untouched <= 1'b0;
    end
  end

  // Checks
  property p_mask_reset;
    @(posedge clk_sys) disable iff (!reset_n)
    mask_untouched |-> (alarm_source_mask == 8'h3f);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask left its reset value");

  property p_lane_buf_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (alarm_status_flags[5] && !alarm_source_mask[5]) |-> alarm_out;
  endproperty
  a_lane_buf_gate: assert property (p_lane_buf_gate) else $error("lane fault not raised");

  property p_serdes_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (alarm_status_flags[4] && !alarm_source_mask[4]) |-> alarm_out;
  endproperty
  a_serdes_gate: assert property (p_serdes_gate) else $error("lock loss not raised");

  property p_link_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (alarm_status_flags[3] && !alarm_source_mask[3]) |-> alarm_out;
  endproperty
  a_link_gate: assert property (p_link_gate) else $error("link fault not raised");

  property p_realign_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (alarm_status_flags[2] && !alarm_source_mask[2]) |-> alarm_out;
  endproperty
  a_realign_gate: assert property (p_realign_gate) else $error("realign not raised");

  property p_divider_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (alarm_status_flags[0] && !alarm_source_mask[0]) |-> alarm_out;
  endproperty
  a_divider_gate: assert property (p_divider_gate) else $error("divider not raised");

  property p_all_masked;
    @(posedge clk_sys) disable iff (!reset_n)
    ((alarm_source_mask | ~alarm_status_flags | 8'hc2) == 8'hff) |-> !alarm_out;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("masked flag raised alarm");

  property p_lane_set;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && lane_event[0]) |=> (lane_buffer_fault_flags[0] && alarm_status_flags[5]);
  endproperty
  a_lane_set: assert property (p_lane_set) else $error("lane fault not recorded");

  property p_lane_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && wr_lane && reg_wdata[1] && !lane_event[1]) |=> !lane_buffer_fault_flags[1];
  endproperty
  a_lane_clear: assert property (p_lane_clear) else $error("lane bit not cleared");

  property p_lane_all_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && clr_lane_all && !lane_any) |=> (lane_buffer_fault_flags == '0);
  endproperty
  a_lane_all_clear: assert property (p_lane_all_clear) else $error("lanes not cleared");

  property p_fuse_load;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && fuse_load && !wr_trim1) |=> (core1_offset == $past(fuse_core1_trim));
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("fuse trim not loaded");

  property p_read_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && reg_rd && reg_addr == `AMOT_ADDR_MASK)
      |=> (reg_rdata == {8'h00, $past(alarm_source_mask)});
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read wrong");

  // Trim writes reach the core outputs one cycle later
  property p_trim0_write;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && wr_trim0) |=> (core0_offset == $past(reg_wdata[11:0]));
  endproperty
  a_trim0_write: assert property (p_trim0_write) else $error("core0 trim not applied");

  property p_trim1_write;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && wr_trim1) |=> (core1_offset == $past(reg_wdata[11:0]));
  endproperty
  a_trim1_write: assert property (p_trim1_write) else $error("core1 trim not applied");

  property p_trim2a_write;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && wr_trim2a) |=> (core2_input_a_offset == $past(reg_wdata[11:0]));
  endproperty
  a_trim2a_write: assert property (p_trim2a_write) else $error("core2 trim not applied");

  // Summary lane flag clears on a write of one when no lane fault is pending
  property p_status_lane_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && wr_status && reg_wdata[5] && !lane_any) |=> !alarm_status_flags[5];
  endproperty
  a_status_lane_clear: assert property (p_status_lane_clear) else $error("lane summary kept");

  // A fault on an inactive lane leaves its flag alone
  property p_lane_inactive;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && !lane_active[6] && !lane_buffer_fault_flags[6]) |=> !lane_buffer_fault_flags[6];
  endproperty
  a_lane_inactive: assert property (p_lane_inactive) else $error("inactive lane recorded");

  // Read data returns to zero without a read strobe
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    (ce && !reg_rd) |=> (reg_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // Clock enable low freezes the state
  property p_ce_freeze;
    @(posedge clk_sys) disable iff (!reset_n)
    !ce |=> ($stable(alarm_source_mask) && $stable(lane_buffer_fault_flags));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

  c_unmasked_alarm: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(alarm_out));
  c_lane_clear: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ce && wr_lane ##1 !lane_buffer_fault_flags[0]);
  c_fuse_load: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ce && fuse_load);
  c_lane_persist: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ce && wr_lane && ((reg_wdata[LANES-1:0] & lane_event) != '0));
  c_ce_freeze: cover property (@(posedge clk_sys) disable iff (!reset_n)
    !ce && reg_wr);

endmodule

// file: amot_cfg.svh
`ifndef AMOT_CFG_SVH
`define AMOT_CFG_SVH
// Register offsets
`define AMOT_ADDR_SUMMARY   10'h2c0
`define AMOT_ADDR_STATUS    10'h2c1
`define AMOT_ADDR_MASK      10'h2c2
`define AMOT_ADDR_LANE      10'h2c4
`define AMOT_ADDR_TRIM0     10'h330
`define AMOT_ADDR_TRIM1     10'h332
`define AMOT_ADDR_TRIM2A    10'h334
// Reset values
`define AMOT_RST_MASK       8'h3f
`define AMOT_RST_STATUS     8'h3f
`define AMOT_RST_LANE       8'hff
`define AMOT_RST_TRIM       16'h0000
// Field positions in mask and status
`define AMOT_BIT_LANE_BUF   5
`define AMOT_BIT_SERDES     4
`define AMOT_BIT_LINK       3
`define AMOT_BIT_REALIGN    2
`define AMOT_BIT_DIVIDER    0
// Status bits that may raise the summary alarm
`define AMOT_ALARM_SRC      8'h3d
`endif

// file: amot_pkg.sv
package amot_pkg;
  typedef logic [7:0]  amot_byte_t;
  typedef logic [15:0] amot_word_t;
  typedef logic [9:0]  amot_addr_t;
  typedef logic [11:0] amot_trim_t;
endpackage

// file: tb_top.sv
`timescale 1ns/1ps
`include "amot_cfg.svh"
module tb_top import amot_pkg::*; ;
  logic       clk_sys = 1'b0;
  logic       reset_n, reg_wr, reg_rd, fuse_load, alarm_out, ce;
  amot_addr_t reg_addr;
  amot_word_t reg_wdata, reg_rdata;
  amot_byte_t lane_active, lerr;
  logic [5:0] evv;
  amot_trim_t core0_offset, core1_offset, core2_input_a_offset;
  int         n_mismatch = 0;
  int         total_checks = 0;
  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;
  amot_regs dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lane_active(lane_active), .lane_fifo_err(lerr | {7'h00, evv[5]}),
    .serdes_lock_lost(evv[4]), .link_state_fault(evv[3]), .clock_realigned(evv[2]),
    .divider_mismatch(evv[0]), .fuse_load(fuse_load), .fuse_core0_trim(12'h5a5),
    .fuse_core1_trim(12'h3c3), .fuse_core2_input_a_trim(12'h00f), .alarm_out(alarm_out),
    .core0_offset(core0_offset), .core1_offset(core1_offset),
    .core2_input_a_offset(core2_input_a_offset));
  // Compare and count
  task automatic chk(input string name, input amot_word_t seen, input amot_word_t exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Single-cycle bus write
  task automatic wr(input amot_addr_t a, input amot_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read, data taken in the cycle after the strobe
  task automatic rdchk(input amot_addr_t a, input amot_word_t exp, input string name);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset;
    rdchk(`AMOT_ADDR_MASK, 16'h003f, "mask");
    rdchk(`AMOT_ADDR_LANE, 16'h00ff, "lane");
    wr(`AMOT_ADDR_LANE, 16'h000f);
    rdchk(`AMOT_ADDR_LANE, 16'h00f0, "lane part");
    chk("alarm", {15'h0, alarm_out}, 16'h0000);
  endtask
  // Unmask one source at a time, fire it, then mask it again
  task automatic t_alarm;
    int bits[5] = '{5, 4, 3, 2, 0};
    amot_word_t m;
    wr(`AMOT_ADDR_STATUS, 16'h003f);
    foreach (bits[i]) begin
      m = 16'h003f & ~(16'h0001 << bits[i]);
      wr(`AMOT_ADDR_MASK, m);
      rdchk(`AMOT_ADDR_MASK, m, "mask rb");
      settle();
      chk("alarm idle", {15'h0, alarm_out}, 16'h0000);
      @(posedge clk_sys);
      evv[bits[i]] <= 1'b1;
      @(posedge clk_sys);
      evv[bits[i]] <= 1'b0;
      settle();
      chk("alarm fired", {15'h0, alarm_out}, 16'h0001);
      rdchk(`AMOT_ADDR_SUMMARY, 16'h0001, "summary");
      wr(`AMOT_ADDR_MASK, 16'h003f);
      settle();
      chk("alarm masked", {15'h0, alarm_out}, 16'h0000);
      wr(`AMOT_ADDR_STATUS, 16'h003f);
    end
  endtask
  // Lane flags: set, inactive lane, clear loses to event, summary clear
  task automatic t_lane;
    wr(`AMOT_ADDR_LANE, 16'h00ff);
    rdchk(`AMOT_ADDR_LANE, 16'h0000, "lane w1c");
    @(posedge clk_sys);
    lane_active <= 8'hbf;
    lerr <= 8'h48;
    @(posedge clk_sys);
    lerr <= 8'h00;
    settle();
    rdchk(`AMOT_ADDR_LANE, 16'h0008, "lane set");
    rdchk(`AMOT_ADDR_STATUS, 16'h0020, "status lane");
    @(posedge clk_sys);
    lerr <= 8'h02;
    wr(`AMOT_ADDR_LANE, 16'h0002);
    lerr <= 8'h00;
    rdchk(`AMOT_ADDR_LANE, 16'h000a, "lane persist");
    wr(`AMOT_ADDR_STATUS, 16'h0020);
    rdchk(`AMOT_ADDR_LANE, 16'h0000, "lane all");
    rdchk(`AMOT_ADDR_STATUS, 16'h0000, "status clr");
    @(posedge clk_sys);
    lane_active <= 8'hff;
  endtask
  // Trim write, outputs, fuse defaults, unmapped place
  task automatic t_trim;
    // Calibration stays idle throughout, so trims may be touched at once
    wr(`AMOT_ADDR_TRIM0, 16'h0abc);
    wr(`AMOT_ADDR_TRIM1, 16'h0123);
    wr(`AMOT_ADDR_TRIM2A, 16'h0fff);
    settle();
    chk("core0", {4'h0, core0_offset}, 16'h0abc);
    chk("core1", {4'h0, core1_offset}, 16'h0123);
    chk("core2a", {4'h0, core2_input_a_offset}, 16'h0fff);
    rdchk(`AMOT_ADDR_TRIM1, 16'h0123, "trim1 rb");
    @(posedge clk_sys);
    fuse_load <= 1'b1;
    @(posedge clk_sys);
    fuse_load <= 1'b0;
    settle();
    chk("fuse0", {4'h0, core0_offset}, 16'h05a5);
    chk("fuse2a", {4'h0, core2_input_a_offset}, 16'h000f);
    rdchk(`AMOT_ADDR_TRIM1, 16'h03c3, "fuse1 rb");
    wr(10'h2c3, 16'h00ff);
    rdchk(10'h2c3, 16'h0000, "unmapped");
    rdchk(`AMOT_ADDR_MASK, 16'h003f, "mask kept");
  endtask
  // Clock enable low: a mask write strobe and a lane fault are ignored
  task automatic t_ce;
    @(posedge clk_sys);
    ce <= 1'b0;
    lerr <= 8'h01;
    wr(`AMOT_ADDR_MASK, 16'h0000);
    ce <= 1'b1;
    lerr <= 8'h00;
    rdchk(`AMOT_ADDR_MASK, 16'h003f, "ce mask");
    rdchk(`AMOT_ADDR_LANE, 16'h0000, "ce lane");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fuse_load = 1'b0;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    lane_active = 8'hff;
    lerr = 8'h00;
    evv = 6'h00;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_alarm();
    t_lane();
    t_trim();
    t_ce();
    print_verdict();
  end
  // Watchdog well beyond the roughly 160 cycles the tests need
  initial begin
    #(25 * 4000);
    n_mismatch++;
    print_verdict();
  end
endmodule
